// File: logic/gicp_pkg.sv
// constants of the gauge serial command port: timing, address map, field layout
// assumes a 125 MHz reference clock; shared by the port engine and its word memory
package gicp_pkg;

	// timing in milliseconds and the cycle counts derived from it
	localparam int unsigned CLK_KHZ = 125000;
	localparam int unsigned STUCK_BUS_MS = 2000;
	localparam int unsigned FLASH_STRETCH_MS = 80;
	localparam int unsigned REST_STRETCH_MS = 270;
	localparam int unsigned REFRESH_MS = 1000;
	localparam int unsigned STUCK_BUS_CYC = STUCK_BUS_MS * CLK_KHZ;
	localparam int unsigned FLASH_STRETCH_CYC = FLASH_STRETCH_MS * CLK_KHZ;
	localparam int unsigned REST_STRETCH_CYC = REST_STRETCH_MS * CLK_KHZ;
	localparam int unsigned REFRESH_CYC = REFRESH_MS * CLK_KHZ;
	localparam logic [2:0] SETTLE_CYC = 3'h4;

	// widths
	localparam int unsigned WORD_W = 16;
	localparam int unsigned MEM_AW = 5;

	// bus address and command range
	localparam logic [6:0] DEV_ADDR = 7'h55;
	localparam logic [7:0] CMD_MAX = 8'h7F;
	localparam logic [6:0] MAP_END = 7'h38;

	// command code of the low byte of each word
	localparam logic [6:0] OFS_HOST_CONTROL_WORD = 7'h00;
	localparam logic [6:0] OFS_HYPOTHETICAL_LOAD_CURRENT = 7'h02;
	localparam logic [6:0] OFS_RAW_CHARGE_PERCENT = 7'h04;
	localparam logic [6:0] OFS_PACK_TEMPERATURE = 7'h06;
	localparam logic [6:0] OFS_CELL_VOLTAGE = 7'h08;
	localparam logic [6:0] OFS_GAUGE_STATUS_FLAGS = 7'h0A;
	localparam logic [6:0] OFS_NOMINAL_USABLE_CAPACITY = 7'h0C;
	localparam logic [6:0] OFS_FULL_USABLE_CAPACITY = 7'h0E;
	localparam logic [6:0] OFS_CHARGE_LEFT = 7'h10;
	localparam logic [6:0] OFS_CAPACITY_WHEN_FULL = 7'h12;
	localparam logic [6:0] OFS_MEAN_CURRENT = 7'h14;
	localparam logic [6:0] OFS_MINUTES_UNTIL_DEPLETED = 7'h16;
	localparam logic [6:0] OFS_SMOOTHED_FULL_CAPACITY = 7'h18;
	localparam logic [6:0] OFS_PROTECTION_STATE = 7'h1A;
	localparam logic [6:0] OFS_RAW_FULL_CAPACITY = 7'h1C;
	localparam logic [6:0] OFS_PEAK_CURRENT_LIMIT = 7'h1E;
	localparam logic [6:0] OFS_RAW_CHARGE_LEFT = 7'h20;
	localparam logic [6:0] OFS_SMOOTHED_CHARGE_LEFT = 7'h22;
	localparam logic [6:0] OFS_LOW_CHARGE_ALERT_SET = 7'h24;
	localparam logic [6:0] OFS_LOW_CHARGE_ALERT_CLEAR = 7'h26;
	localparam logic [6:0] OFS_DIE_TEMPERATURE = 7'h28;
	localparam logic [6:0] OFS_CHARGE_CYCLE_TOTAL = 7'h2A;
	localparam logic [6:0] OFS_CHARGE_PERCENT = 7'h2C;
	localparam logic [6:0] OFS_BATTERY_HEALTH = 7'h2E;
	localparam logic [6:0] OFS_REQUESTED_CHARGE_VOLTAGE = 7'h30;
	localparam logic [6:0] OFS_REQUESTED_CHARGE_CURRENT = 7'h32;
	localparam logic [6:0] OFS_ACCUMULATED_CHARGE_FLOW = 7'h34;
	localparam logic [6:0] OFS_LEAKAGE_CURRENT_ESTIMATE = 7'h34;
	localparam logic [6:0] OFS_DEPTH_OF_DISCHARGE_AT_REST = 7'h36;

	// low byte sits at the even code, high byte at the odd code
	localparam int unsigned LO_LSB = 0;
	localparam int unsigned HI_LSB = 8;

endpackage : gicp_pkg

// File: logic/gicp_port.sv
// serial command port engine of a battery gauge: bus target, pointer, timeouts
// assumes bus pins are open drain outside, gauge-side inputs share ref_clk_in
//
// What this block does
// - answer only target address 1010101, 0xAA write and 0xAB read
// - serve one-byte write, quick read, one-byte read and incremental read
// - quick read returns the byte at the current address pointer
// - pointer advances on every acknowledged data byte, either direction
// - a write lands in its command code through the pointer, which then moves to the next code
// - write to a read-only code is not acknowledged and stores nothing
// - command code above 0x7F is not acknowledged
// - every data byte after the first in one write is not acknowledged
// - bus low about two seconds releases both clock and data lines
// - lines still held low after release send the engine to sleep
// - clock may be stretched up to 80 ms during flash updates
// - clock may be stretched up to 270 ms after a rest voltage command
// - measurement words refresh only once per second
// - each command is a 16-bit word on a pair of codes
// - commands are served only in the normal operating state
// - cell voltage refreshes once every second in normal state
// - offset calibration runs before the engine sleeps
`timescale 1ns/1ns
module gicp_port
#(
	parameter int unsigned STUCK_BUS_CYC = gicp_pkg::STUCK_BUS_CYC,
	parameter int unsigned FLASH_STRETCH_CYC = gicp_pkg::FLASH_STRETCH_CYC,
	parameter int unsigned REST_STRETCH_CYC = gicp_pkg::REST_STRETCH_CYC,
	parameter int unsigned REFRESH_CYC = gicp_pkg::REFRESH_CYC
)
(
	// clock and reset
	input wire logic ref_clk_in,
	input wire logic sys_rst_in,
	// serial bus pins
	input wire logic scl_in,
	output logic scl_out,
	output logic scl_oe_out,
	input wire logic sda_in,
	output logic sda_out,
	output logic sda_oe_out,
	// gauge status
	input wire logic gauge_normal_in,
	input wire logic flash_busy_in,
	input wire logic rest_voltage_measure_cmd_in,
	// measurement refresh
	input wire logic meas_we_in,
	input wire logic [gicp_pkg::MEM_AW-1:0] meas_idx_in,
	input wire logic [gicp_pkg::WORD_W-1:0] meas_data_in,
	input wire logic meas_done_in,
	output logic refresh_req_out,
	// calibration and sleep
	input wire logic cal_done_in,
	output logic cal_req_out,
	output logic sleep_out,
	// host control word
	output logic [gicp_pkg::WORD_W-1:0] ctrl_word_out,
	output logic ctrl_strobe_out
);
	import gicp_pkg::*;

	if (STUCK_BUS_CYC < 16 || REFRESH_CYC < 2 || FLASH_STRETCH_CYC < 1
		|| REST_STRETCH_CYC < 1)
	begin : g_bad_counts
		$error("gicp_port: counts too small");
	end

	typedef enum logic [3:0] {
		ST_IDLE, ST_ADDR, ST_ADDR_ACK, ST_CMD, ST_CMD_ACK, ST_WDATA, ST_WDATA_ACK,
		ST_RDATA, ST_RD_ACK, ST_IGNORE, ST_RELEASE, ST_CAL, ST_SLEEP
	} gicp_state_t;

	typedef struct packed {
		gicp_state_t st;
		logic [1:0] scl_sync;
		logic [1:0] sda_sync;
		logic scl_prev;
		logic sda_prev;
		logic [7:0] sh;
		logic [3:0] bits;
		logic [6:0] ptr;
		logic rnw;
		logic wrote;
		logic rd_ok;
		logic [7:0] tx;
		logic sda_oe;
		logic scl_oe;
		logic [31:0] low_cnt;
		logic [31:0] str_cnt;
		logic [31:0] sec_cnt;
		logic refresh;
		logic [2:0] rel_cnt;
		logic [WORD_W-1:0] ctrl_word;
		logic ctrl_stb;
	} gicp_regs_t;

	gicp_regs_t q;
	gicp_regs_t d;

	logic scl_s;
	logic sda_s;
	logic rise;
	logic fall;
	logic start_c;
	logic stop_c;
	logic byte_end;
	logic [WORD_W-1:0] rd_word;
	logic [7:0] rd_byte;
	logic host_we;
	logic [1:0] host_be;
	logic meas_we;
	logic [31:0] str_cap;
	logic in_ack;
	logic [WORD_W-1:0] rd_word_mem;

	// write permission by command code
	function automatic logic is_rw(input logic [6:0] code);
		logic [5:0] w;
		w = code[6:1];
		is_rw = (w == OFS_HOST_CONTROL_WORD[6:1]) || (w == OFS_HYPOTHETICAL_LOAD_CURRENT[6:1])
			|| (w == OFS_LOW_CHARGE_ALERT_SET[6:1]) || (w == OFS_LOW_CHARGE_ALERT_CLEAR[6:1]);
	endfunction : is_rw

	////////////////////////////////////////////////////////////////////////////////
	// pin edges and read byte

	assign scl_s = q.scl_sync[1];
	assign sda_s = q.sda_sync[1];
	assign rise = scl_s && !q.scl_prev;
	assign fall = !scl_s && q.scl_prev;
	assign start_c = scl_s && q.scl_prev && q.sda_prev && !sda_s;
	assign stop_c = scl_s && q.scl_prev && !q.sda_prev && sda_s;
	assign byte_end = fall && (q.bits == 4'h8);
	assign rd_word = (q.ptr < MAP_END) ? rd_word_mem : '0;
	assign rd_byte = q.ptr[0] ? rd_word[WORD_W-1:HI_LSB] : rd_word[HI_LSB-1:LO_LSB];
	assign in_ack = (q.st == ST_ADDR_ACK) || (q.st == ST_CMD_ACK) || (q.st == ST_WDATA_ACK);
	assign str_cap = rest_voltage_measure_cmd_in ? REST_STRETCH_CYC : FLASH_STRETCH_CYC;

	////////////////////////////////////////////////////////////////////////////////
	// next state

	always_comb
	begin
		d = q;
		host_we = 1'b0;
		host_be = q.ptr[0] ? 2'b10 : 2'b01;
		d.scl_sync = {q.scl_sync[0], scl_in};
		d.sda_sync = {q.sda_sync[0], sda_in};
		d.scl_prev = scl_s;
		d.sda_prev = sda_s;
		d.ctrl_stb = 1'b0;
		// once-per-second refresh window
		if (meas_done_in)
			d.refresh = 1'b0;
		if (q.sec_cnt >= REFRESH_CYC - 1)
		begin
			d.sec_cnt = '0;
			d.refresh = 1'b1;
		end
		else
			d.sec_cnt = q.sec_cnt + 32'h1;
		// stuck bus counter
		if ((!scl_s || !sda_s) && q.st != ST_RELEASE && q.st != ST_CAL && q.st != ST_SLEEP)
			d.low_cnt = q.low_cnt + 32'h1;
		else
			d.low_cnt = '0;
		// byte shift on rising clock
		if (rise && (q.st == ST_ADDR || q.st == ST_CMD || q.st == ST_WDATA))
		begin
			d.sh = {q.sh[6:0], sda_s};
			d.bits = q.bits + 4'h1;
		end
		case (q.st)
			ST_ADDR:
			begin
				if (byte_end)
				begin
					d.bits = '0;
					d.rnw = q.sh[0];
					if (q.sh[7:1] == DEV_ADDR && gauge_normal_in)
					begin
						d.sda_oe = 1'b1;
						d.st = ST_ADDR_ACK;
					end
					else
						d.st = ST_IGNORE;
				end
			end
			ST_ADDR_ACK:
			begin
				if (fall)
				begin
					d.bits = '0;
					if (q.rnw)
					begin
						d.tx = rd_byte;
						d.sda_oe = !rd_byte[7];
						d.st = ST_RDATA;
					end
					else
					begin
						d.sda_oe = 1'b0;
						d.wrote = 1'b0;
						d.st = ST_CMD;
					end
				end
			end
			ST_CMD:
			begin
				if (byte_end)
				begin
					d.bits = '0;
					if (q.sh <= CMD_MAX)
					begin
						d.ptr = q.sh[6:0];
						d.sda_oe = 1'b1;
						d.st = ST_CMD_ACK;
					end
					else
						d.st = ST_IGNORE;
				end
			end
			ST_CMD_ACK:
			begin
				if (fall)
				begin
					d.sda_oe = 1'b0;
					d.st = ST_WDATA;
				end
			end
			ST_WDATA:
			begin
				if (byte_end)
				begin
					d.bits = '0;
					d.st = ST_WDATA_ACK;
					if (!q.wrote && is_rw(q.ptr))
					begin
						host_we = 1'b1;
						d.sda_oe = 1'b1;
						d.wrote = 1'b1;
						d.ptr = q.ptr + 7'h1;
						if (q.ptr[6:1] == OFS_HOST_CONTROL_WORD[6:1])
						begin
							if (q.ptr[0])
							begin
								d.ctrl_word[WORD_W-1:HI_LSB] = q.sh;
								d.ctrl_stb = 1'b1;
							end
							else
								d.ctrl_word[HI_LSB-1:LO_LSB] = q.sh;
						end
					end
				end
			end
			ST_WDATA_ACK:
			begin
				if (fall)
				begin
					d.sda_oe = 1'b0;
					d.st = ST_WDATA;
				end
			end
			ST_RDATA:
			begin
				if (fall)
				begin
					if (q.bits == 4'h7)
					begin
						d.sda_oe = 1'b0;
						d.st = ST_RD_ACK;
					end
					else
					begin
						d.bits = q.bits + 4'h1;
						d.tx = {q.tx[6:0], 1'b0};
						d.sda_oe = !q.tx[6];
					end
				end
			end
			ST_RD_ACK:
			begin
				if (rise)
				begin
					d.rd_ok = !sda_s;
					if (!sda_s)
						d.ptr = q.ptr + 7'h1;
				end
				if (fall)
				begin
					d.bits = '0;
					if (q.rd_ok)
					begin
						d.tx = rd_byte;
						d.sda_oe = !rd_byte[7];
						d.st = ST_RDATA;
					end
					else
						d.st = ST_IGNORE;
				end
			end
			ST_RELEASE:
			begin
				d.rel_cnt = q.rel_cnt + 3'h1;
				if (q.rel_cnt >= SETTLE_CYC)
					d.st = (!scl_s || !sda_s) ? ST_CAL : ST_IDLE;
			end
			ST_CAL:
			begin
				if (cal_done_in)
					d.st = ST_SLEEP;
			end
			ST_SLEEP:
			begin
				if (scl_s && sda_s)
					d.st = ST_IDLE;
			end
			default:
			begin
			end
		endcase
		// start and stop conditions
		if (q.st != ST_RELEASE && q.st != ST_CAL && q.st != ST_SLEEP)
		begin
			if (start_c)
			begin
				d.st = ST_ADDR;
				d.bits = '0;
				d.sda_oe = 1'b0;
			end
			else if (stop_c)
			begin
				d.st = ST_IDLE;
				d.sda_oe = 1'b0;
			end
		end
		// clock stretch in the acknowledge low phase
		if (in_ack && d.st == q.st && !scl_s && (flash_busy_in || rest_voltage_measure_cmd_in)
			&& q.str_cnt < str_cap)
		begin
			d.scl_oe = 1'b1;
			d.str_cnt = q.str_cnt + 32'h1;
		end
		else
			d.scl_oe = 1'b0;
		if (!in_ack)
			d.str_cnt = '0;
		// stuck bus release
		if (q.low_cnt >= STUCK_BUS_CYC - 1)
		begin
			d.st = ST_RELEASE;
			d.sda_oe = 1'b0;
			d.scl_oe = 1'b0;
			d.low_cnt = '0;
			d.rel_cnt = '0;
		end
		host_we = host_we && (d.st == ST_WDATA_ACK);
	end

	always_ff @(posedge ref_clk_in)
	begin
		if (sys_rst_in)
		begin
			q <= '0;
			q.st <= ST_IDLE;
			q.scl_sync <= 2'b11;
			q.sda_sync <= 2'b11;
			q.scl_prev <= 1'b1;
			q.sda_prev <= 1'b1;
		end
		else
			q <= d;
	end

	////////////////////////////////////////////////////////////////////////////////
	// word memory

	assign meas_we = meas_we_in && q.refresh && !is_rw({1'b0, meas_idx_in, 1'b0});

	gicp_regmem #(.AW(MEM_AW), .DW(WORD_W)) u_mem (
		.ref_clk_in(ref_clk_in),
		.sys_rst_in(sys_rst_in),
		.a_we_in(host_we),
		.a_be_in(host_be),
		.a_addr_in(q.ptr[MEM_AW:1]),
		.a_data_in({q.sh, q.sh}),
		.b_we_in(meas_we),
		.b_addr_in(meas_idx_in),
		.b_data_in(meas_data_in),
		.rd_addr_in(q.ptr[MEM_AW:1]),
		.rd_data_out(rd_word_mem)
	);

	////////////////////////////////////////////////////////////////////////////////
	// outputs

	assign scl_out = 1'b0;
	assign sda_out = 1'b0;
	assign scl_oe_out = q.scl_oe;
	assign sda_oe_out = q.sda_oe;
	assign refresh_req_out = q.refresh;
	assign cal_req_out = (q.st == ST_CAL);
	assign sleep_out = (q.st == ST_SLEEP);
	assign ctrl_word_out = q.ctrl_word;
	assign ctrl_strobe_out = q.ctrl_stb;

	////////////////////////////////////////////////////////////////////////////////
	// checks

	default clocking cb @(posedge ref_clk_in);
	endclocking
	default disable iff (sys_rst_in);

	addr_nack_a: assert property (
		(q.st == ST_ADDR && byte_end && !start_c && q.low_cnt < STUCK_BUS_CYC - 1
		&& q.sh[7:1] != DEV_ADDR) |=> (q.st == ST_IGNORE && !sda_oe_out))
		else $error("foreign address acknowledged");
	addr_ack_a: assert property (
		(q.st == ST_ADDR && byte_end && !start_c && q.low_cnt < STUCK_BUS_CYC - 1
		&& q.sh[7:1] == DEV_ADDR && gauge_normal_in) |=> sda_oe_out ##1 sda_oe_out)
		else $error("own address not acknowledged");
	cmd_range_a: assert property (
		(q.st == ST_CMD && byte_end && q.sh[7]) |=> !sda_oe_out)
		else $error("command above range acknowledged");
	ro_write_a: assert property (
		(q.st == ST_WDATA && byte_end && !is_rw(q.ptr)) |-> !host_we ##1 !sda_oe_out)
		else $error("read-only code written");
	extra_write_a: assert property (
		(q.st == ST_WDATA && byte_end && q.wrote) |-> !host_we ##1 !sda_oe_out)
		else $error("extra write byte taken");
	ptr_adv_a: assert property (
		(q.st == ST_RD_ACK && rise && !sda_s && !start_c && q.low_cnt < STUCK_BUS_CYC - 1)
		|=> q.ptr == $past(q.ptr) + 7'h1)
		else $error("pointer did not advance");
	quick_read_a: assert property (
		(q.st == ST_ADDR_ACK && fall && q.rnw && q.low_cnt < STUCK_BUS_CYC - 1)
		|=> (q.tx == $past(rd_byte) && sda_oe_out == !$past(rd_byte[7])))
		else $error("read byte not from pointer");
	timeout_a: assert property (
		(q.low_cnt >= STUCK_BUS_CYC - 1) |=> (q.st == ST_RELEASE && !sda_oe_out && !scl_oe_out)
		[*2])
		else $error("stuck bus not released");
	sleep_cal_a: assert property (
		$rose(sleep_out) |-> $past(cal_req_out))
		else $error("sleep without calibration");
	refresh_gate_a: assert property (
		meas_we |-> (refresh_req_out && meas_idx_in != OFS_HOST_CONTROL_WORD[5:1]
		&& meas_idx_in != OFS_HYPOTHETICAL_LOAD_CURRENT[5:1]
		&& meas_idx_in != OFS_LOW_CHARGE_ALERT_SET[5:1]
		&& meas_idx_in != OFS_LOW_CHARGE_ALERT_CLEAR[5:1]))
		else $error("measurement written outside refresh");
	stretch_cap_a: assert property (
		scl_oe_out |-> (q.str_cnt <= REST_STRETCH_CYC && in_ack))
		else $error("stretch beyond limit");

	quick_read_c: cover property (q.st == ST_ADDR_ACK && fall && q.rnw);
	write_ok_c: cover property (host_we ##1 sda_oe_out);
	timeout_c: cover property (q.st == ST_RELEASE);
	sleep_c: cover property (sleep_out);

endmodule : gicp_port

// File: logic/gicp_regmem.sv
// word memory behind the command codes, two write ports and a registered read
// assumes both write ports never hit the same byte lane in one cycle
`timescale 1ns/1ns
module gicp_regmem
#(
	parameter int unsigned AW = 5,
	parameter int unsigned DW = 16
)
(
	// clock and reset
	input wire logic ref_clk_in,
	input wire logic sys_rst_in,
	// byte write port
	input wire logic a_we_in,
	input wire logic [1:0] a_be_in,
	input wire logic [AW-1:0] a_addr_in,
	input wire logic [DW-1:0] a_data_in,
	// word write port
	input wire logic b_we_in,
	input wire logic [AW-1:0] b_addr_in,
	input wire logic [DW-1:0] b_data_in,
	// read port
	input wire logic [AW-1:0] rd_addr_in,
	output logic [DW-1:0] rd_data_out
);
	import gicp_pkg::*;

	if (DW != 16 || AW < 1)
	begin : g_bad_shape
		$error("gicp_regmem: data must be 16 bits wide");
	end

	typedef struct packed {
		logic [(2**AW)-1:0][DW-1:0] mem;
		logic [DW-1:0] rd;
	} gicp_mem_t;

	gicp_mem_t q;
	gicp_mem_t d;

	always_comb
	begin
		d = q;
		if (a_we_in && a_be_in[0])
			d.mem[a_addr_in][HI_LSB-1:LO_LSB] = a_data_in[HI_LSB-1:LO_LSB];
		if (a_we_in && a_be_in[1])
			d.mem[a_addr_in][DW-1:HI_LSB] = a_data_in[DW-1:HI_LSB];
		if (b_we_in)
			d.mem[b_addr_in] = b_data_in;
		d.rd = q.mem[rd_addr_in];
	end

	always_ff @(posedge ref_clk_in)
	begin
		if (sys_rst_in)
			q <= '0;
		else
			q <= d;
	end

	assign rd_data_out = q.rd;

endmodule : gicp_regmem

// File: tb/gicp_host.sv
// host side bus master model: start, stop, byte write and byte read
// assumes open-drain lines with pull-ups resolved by the bench
`timescale 1ns/1ns
module gicp_host
(
	// resolved bus levels
	input wire logic scl_in,
	input wire logic sda_in,
	// pull-down enables
	output logic scl_low_out,
	output logic sda_low_out
);
	initial
	begin
		scl_low_out = 1'b0;
		sda_low_out = 1'b0;
	end
	////////////////////////////////////////////////////////////////////////////////
	// release the clock and wait out a stretch by the target of up to 20000 ns
	task automatic clk_high();
		int n;
		n = 0;
		scl_low_out = 1'b0;
		#1;
		while (scl_in !== 1'b1 && n < 20000)
		begin
			#1;
			n++;
		end
	endtask : clk_high
	task automatic hold(input logic v);
		scl_low_out = v;
	endtask : hold
	task automatic bit_xfer(input logic b, output logic s);
		#31 sda_low_out = ~b;
		#31 clk_high();
		#31 s = sda_in;
		#32 scl_low_out = 1'b1;
	endtask : bit_xfer
	task automatic start();
		#31 sda_low_out = 1'b0;
		#31 clk_high();
		#63 sda_low_out = 1'b1;
		#63 scl_low_out = 1'b1;
	endtask : start
	task automatic stop();
		#31 sda_low_out = 1'b1;
		#31 clk_high();
		#63 sda_low_out = 1'b0;
		#63;
	endtask : stop
	task automatic wbyte(input logic [7:0] b, output logic ack);
		logic s;
		for (int i = 7; i >= 0; i--)
		begin
			bit_xfer(b[i], s);
		end
		bit_xfer(1'b1, s);
		ack = ~s;
	endtask : wbyte
	task automatic rbyte(input logic ack_it, output logic [7:0] b);
		logic s;
		for (int i = 7; i >= 0; i--)
		begin
			bit_xfer(1'b1, s);
			b[i] = s;
		end
		bit_xfer(~ack_it, s);
	endtask : rbyte
endmodule : gicp_host

// File: tb/tb_gauge_i2c_command_port.sv
// self-checking bench of the gauge serial command port
// assumes gicp_pkg and gicp_port compiled before, host model in gicp_host
`timescale 1ns/1ns
module tb_gauge_i2c_command_port;
	import gicp_pkg::*;
	localparam int unsigned FLASH_T = 50;
	localparam int unsigned REST_T = 100;
	localparam int unsigned REFRESH_T = 500;
	logic ref_clk_in, sys_rst_in, gauge_normal, flash_busy, rest_cmd, meas_we, meas_done, cal_done;
	logic [4:0] meas_idx;
	logic [15:0] meas_data, ctrl_word, v;
	logic scl_oe, sda_oe, refresh_req, cal_req, sleep, ctrl_strobe, h_scl, h_sda, a;
	wire scl = ~(h_scl | scl_oe);
	wire sda = ~(h_sda | sda_oe);
	int unsigned fails, tests_run, stb_cnt, str_run, str_max, n;
	logic [7:0] bad_cmd [2] = '{8'h80, 8'hFF};
	logic [7:0] bad_adr [3] = '{8'hAC, 8'hA8, 8'h2A};
	////////////////////////////////////////////////////////////////////////////////
	gicp_port #(.STUCK_BUS_CYC(2000), .FLASH_STRETCH_CYC(FLASH_T), .REST_STRETCH_CYC(REST_T),
		.REFRESH_CYC(REFRESH_T)) uut (.ref_clk_in(ref_clk_in), .sys_rst_in(sys_rst_in),
		.scl_in(scl), .scl_out(), .scl_oe_out(scl_oe), .sda_in(sda), .sda_out(),
		.sda_oe_out(sda_oe), .gauge_normal_in(gauge_normal), .flash_busy_in(flash_busy),
		.rest_voltage_measure_cmd_in(rest_cmd), .meas_we_in(meas_we), .meas_idx_in(meas_idx),
		.meas_data_in(meas_data), .meas_done_in(meas_done), .refresh_req_out(refresh_req),
		.cal_done_in(cal_done), .cal_req_out(cal_req), .sleep_out(sleep),
		.ctrl_word_out(ctrl_word), .ctrl_strobe_out(ctrl_strobe));
	gicp_host host (.scl_in(scl), .sda_in(sda), .scl_low_out(h_scl), .sda_low_out(h_sda));
	initial
	begin
		ref_clk_in = 1'b0;
		forever #4 ref_clk_in = ~ref_clk_in;
	end
	// strobe count and longest clock stretch
	always @(negedge ref_clk_in)
	begin
		if (ctrl_strobe === 1'b1) stb_cnt++;
		str_run = (scl_oe === 1'b1) ? str_run + 1 : 0;
		if (str_run > str_max) str_max = str_run;
	end
	////////////////////////////////////////////////////////////////////////////////
	task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
		tests_run++;
		if (seen !== exp)
		begin
			fails++;
			$display("[FAIL] %s expected %h seen %h", what, exp, seen);
		end
	endtask : check
	task automatic end_of_test();
		$display("checks %0d mismatches %0d", tests_run, fails);
		if (fails == 0 && tests_run > 0)
		begin
			$display("Simulation passed");
		end
		else
		begin
			$display("Simulation failed");
		end
		$finish;
	endtask : end_of_test
	// one write transfer of command and one data byte
	task automatic wr(input logic [7:0] cmd, input logic [7:0] d, input logic dack);
		logic k;
		repeat (REFRESH_T / 2) @(negedge ref_clk_in);
		host.start();
		host.wbyte(8'hAA, k);
		check("wr addr ack", 16'(k), 16'h0001);
		host.wbyte(cmd, k);
		check("wr cmd ack", 16'(k), 16'h0001);
		host.wbyte(d, k);
		check("wr data ack", 16'(k), 16'(dack));
		host.stop();
	endtask : wr
	// read of n bytes, low byte first; quick skips the command phase
	task automatic rd(input logic [7:0] cmd, input int n, input logic quick, output logic [15:0] r);
		logic k;
		logic [7:0] b;
		repeat (REFRESH_T / 2) @(negedge ref_clk_in);
		r = 16'h0000;
		if (!quick)
		begin
			host.start();
			host.wbyte(8'hAA, k);
			host.wbyte(cmd, k);
			check("rd cmd ack", 16'(k), 16'h0001);
		end
		host.start();
		host.wbyte(8'hAB, k);
		check("rd addr ack", 16'(k), 16'h0001);
		for (int i = 0; i < n; i++)
		begin
			host.rbyte(i < n - 1, b);
			r[8*i +: 8] = b;
		end
		host.stop();
	endtask : rd
	////////////////////////////////////////////////////////////////////////////////
	initial
	begin
		#600000;
		fails++;
		end_of_test();
	end
	initial
	begin
		{fails, tests_run, stb_cnt, str_run, str_max} = '0;
		sys_rst_in = 1'b1;
		{flash_busy, rest_cmd, meas_we, meas_done, cal_done} = '0;
		gauge_normal = 1'b1;
		meas_idx = 5'h00;
		meas_data = 16'h0000;
		repeat (10) @(posedge ref_clk_in);
		@(negedge ref_clk_in) sys_rst_in = 1'b0;
		repeat (4) @(posedge ref_clk_in);
		wr(8'h02, 8'h34, 1'b1);
		wr(8'h03, 8'h12, 1'b1);
		rd(8'h02, 2, 1'b0, v);
		check("incr read 0x02", v, 16'h1234);
		rd(8'h00, 1, 1'b1, v);
		check("quick read", v, 16'h0012);
		wr(8'h00, 8'h78, 1'b1);
		check("no strobe on low byte", 16'(stb_cnt), 16'h0000);
		wr(8'h01, 8'h56, 1'b1);
		repeat (REFRESH_T / 10) @(negedge ref_clk_in);
		check("control word", ctrl_word, 16'h5678);
		check("strobe count", 16'(stb_cnt), 16'h0001);
		wr(8'h08, 8'h55, 1'b0);
		rd(8'h08, 1, 1'b0, v);
		check("read-only kept", v, 16'h0000);
		host.start();
		host.wbyte(8'hAA, a);
		host.wbyte(8'h24, a);
		host.wbyte(8'hAA, a);
		check("first data ack", 16'(a), 16'h0001);
		host.wbyte(8'hBB, a);
		check("second data nack", 16'(a), 16'h0000);
		host.wbyte(8'hCC, a);
		check("third data nack", 16'(a), 16'h0000);
		host.stop();
		rd(8'h24, 2, 1'b0, v);
		check("extra bytes dropped", v, 16'h00AA);
		foreach (bad_cmd[i])
		begin
			host.start();
			host.wbyte(8'hAA, a);
			host.wbyte(bad_cmd[i], a);
			check("high cmd nack", 16'(a), 16'h0000);
			host.stop();
		end
		foreach (bad_adr[i])
		begin
			host.start();
			host.wbyte(bad_adr[i], a);
			check("foreign addr nack", 16'(a), 16'h0000);
			host.stop();
		end
		@(negedge ref_clk_in) gauge_normal = 1'b0;
		host.start();
		host.wbyte(8'hAA, a);
		check("not normal nack", 16'(a), 16'h0000);
		host.stop();
		@(negedge ref_clk_in) gauge_normal = 1'b1;
		rd(8'h50, 2, 1'b0, v);
		check("unused code", v, 16'h0000);
		rd(8'h7E, 2, 1'b0, v);
		check("top of range", v, 16'h0000);
		@(negedge ref_clk_in) flash_busy = 1'b1;
		str_max = 0;
		wr(8'h26, 8'h5A, 1'b1);
		@(negedge ref_clk_in) flash_busy = 1'b0;
		a = str_max >= FLASH_T - 2 && str_max <= FLASH_T + 1;
		check("flash stretch", 16'(a), 16'h0001);
		@(negedge ref_clk_in) rest_cmd = 1'b1;
		str_max = 0;
		wr(8'h27, 8'hA5, 1'b1);
		@(negedge ref_clk_in) rest_cmd = 1'b0;
		a = str_max >= REST_T - 2 && str_max <= REST_T + 1;
		check("rest stretch", 16'(a), 16'h0001);
		repeat (2 * REFRESH_T) @(negedge ref_clk_in);
		rd(8'h26, 2, 1'b0, v);
		check("stretched writes", v, 16'hA55A);
		@(negedge ref_clk_in) meas_done = 1'b1;
		@(negedge ref_clk_in) meas_done = 1'b0;
		for (n = 0; n < 600 && refresh_req !== 1'b1; n++) @(negedge ref_clk_in);
		check("refresh request", 16'(refresh_req), 16'h0001);
		@(negedge ref_clk_in) {meas_we, meas_idx, meas_data} = {1'b1, 5'h04, 16'hBEEF};
		@(negedge ref_clk_in) {meas_idx, meas_data} = {5'h01, 16'hDEAD};
		@(negedge ref_clk_in) {meas_we, meas_done} = 2'b01;
		@(negedge ref_clk_in) meas_done = 1'b0;
		@(negedge ref_clk_in) {meas_we, meas_idx, meas_data} = {1'b1, 5'h04, 16'h1111};
		@(negedge ref_clk_in) meas_we = 1'b0;
		check("refresh cleared", 16'(refresh_req), 16'h0000);
		rd(8'h08, 2, 1'b0, v);
		check("voltage word", v, 16'hBEEF);
		rd(8'h02, 2, 1'b0, v);
		check("rw word kept", v, 16'h1234);
		host.hold(1'b1);
		for (n = 0; n < 2100 && cal_req !== 1'b1; n++) @(negedge ref_clk_in);
		check("calibration", 16'(cal_req), 16'h0001);
		check("lines released", {14'h0, scl_oe, sda_oe}, 16'h0000);
		check("no sleep yet", 16'(sleep), 16'h0000);
		@(negedge ref_clk_in) cal_done = 1'b1;
		repeat (3) @(posedge ref_clk_in);
		#1 check("sleep", 16'(sleep), 16'h0001);
		@(negedge ref_clk_in) cal_done = 1'b0;
		host.hold(1'b0);
		repeat (8) @(posedge ref_clk_in);
		#1 check("wake", 16'(sleep), 16'h0000);
		wr(8'h24, 8'h77, 1'b1);
		rd(8'h24, 1, 1'b0, v);
		check("after recovery", v, 16'h0077);
		end_of_test();
	end
endmodule : tb_gauge_i2c_command_port
